/* logic/nvm_page_write_erase.sv */
// Our own choices: the placing of the registers and the address-and-strobe port.
`default_nettype none
//Function
//- one page buffer feeds both main array and rww data array
//- each memory write loads buffer and captures address register
//- status bit shows whether page buffer holds loaded data
//- in automatic mode writing last page word starts programming
//- while busy, ready flag low and memory accesses stalled
//- buffer set to all ones after each page program
//- buffer clear command discards buffer contents
//- row erase sets addressed row to ones, rww variant likewise
//- erase of locked row skipped and lock error flag set
//- erase row chosen from any address inside it
//- automatic program uses address captured by last bus write
module nvm_page_write_erase
  import nvm_seq_pkg::*;
#(
  parameter int ADDR_W       = 16,
  parameter int PAGE_WORDS   = 16,
  parameter int ROW_PAGES    = 4,
  parameter int LOCK_REGIONS = 16
) (
  // clock and reset
  input  wire logic                          mclk,
  input  wire logic                          rstn,
  // register port
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [31:0]                   reg_wdata,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  output var  logic [31:0]                   reg_rdata,
  // memory space write port
  input  wire logic                          mem_wr,
  input  wire logic                          mem_rww,
  input  wire logic [ADDR_W-1:0]             mem_addr,
  input  wire logic [31:0]                   mem_wdata,
  output var  logic                          mem_stall,
  // array macro side
  output var  logic                          nvm_prog,
  output var  logic                          nvm_erase,
  output var  logic                          nvm_op_rww,
  output var  logic [ADDR_W-1:0]             nvm_op_addr,
  input  wire logic [$clog2(PAGE_WORDS)-1:0] pb_rd_idx,
  output var  logic [31:0]                   pb_rd_data,
  // interrupt
  output var  logic                          irq
);
  localparam int PW_B = $clog2(PAGE_WORDS);
  localparam int RW_B = $clog2(PAGE_WORDS * ROW_PAGES);
  localparam int LR_B = $clog2(LOCK_REGIONS);

  if ((1 << PW_B) != PAGE_WORDS || (1 << RW_B) != PAGE_WORDS * ROW_PAGES
      || (1 << LR_B) != LOCK_REGIONS || LOCK_REGIONS > 32
      || RW_B + LR_B > ADDR_W || ADDR_W > 32) begin : g_bad
    $error("nvm_page_write_erase: unsupported geometry");
  end
  function automatic logic [ADDR_W-1:0] page_base(
      input logic [ADDR_W-1:0] a);
    page_base = {a[ADDR_W-1:PW_B], {PW_B{1'b0}}};
  endfunction
  function automatic logic [ADDR_W-1:0] row_base(
      input logic [ADDR_W-1:0] a);
    row_base = {a[ADDR_W-1:RW_B], {RW_B{1'b0}}};
  endfunction

  seq_state_t                state;
  seq_state_t                next_state;
  logic [CNT_W-1:0]          cnt;
  logic [CNT_W-1:0]          next_cnt;
  logic                      manual;
  logic                      next_manual;
  logic [ADDR_W-1:0]         nvm_addr;
  logic [ADDR_W-1:0]         next_nvm_addr;
  logic                      loaded;
  logic                      next_loaded;
  logic                      lock_err;
  logic                      next_lock_err;
  logic [IS_W-1:0]           intstat;
  logic [IS_W-1:0]           next_intstat;
  logic [IS_W-1:0]           intmask;
  logic [IS_W-1:0]           next_intmask;
  logic [LOCK_REGIONS-1:0]   lock_bits;
  logic [LOCK_REGIONS-1:0]   next_lock_bits;
  logic [31:0]               next_rdata;
  logic                      next_prog;
  logic                      next_erase;
  logic                      next_op_rww;
  logic [ADDR_W-1:0]         next_op_addr;
  logic                      buf_clear;
  logic [IS_W-1:0]           ev_set;
  logic                      mem_take;
  logic                      auto_go;
  logic                      cmd_go;
  logic [CMD_W-1:0]          cmd;
  logic                      row_locked;

  // stall is registered from next_state, so a write is taken only idle
  assign mem_take = mem_wr && state == S_IDLE;
  assign auto_go  = mem_take && !manual
                    && mem_addr[PW_B-1:0] == PW_B'(PAGE_WORDS - 1);
  assign cmd      = reg_wdata[CMD_LSB +: CMD_W];
  // a memory write in the same cycle wins; the command is dropped
  assign cmd_go   = reg_wr && reg_addr == REG_CTRLA && state == S_IDLE
                    && !mem_wr && reg_wdata[KEY_LSB +: KEY_W] == EXEC_KEY;
  assign row_locked = lock_bits[nvm_addr[ADDR_W-1 -: LR_B]];

  always_comb begin
    next_state    = state;
    next_cnt      = cnt;
    next_manual   = manual;
    next_nvm_addr = nvm_addr;
    next_loaded   = loaded;
    next_lock_err = lock_err;
    next_intmask  = intmask;
    next_lock_bits = lock_bits;
    next_prog     = 1'b0;
    next_erase    = 1'b0;
    next_op_rww   = nvm_op_rww;
    next_op_addr  = nvm_op_addr;
    buf_clear     = 1'b0;
    ev_set        = '0;
    if (cmd_go) begin
      unique case (cmd)
        CMD_WRITE_PAGE, CMD_RWW_WRITE: begin
          next_state   = S_PROG;
          next_cnt     = CNT_W'(PROG_CYC - 1);
          next_prog    = 1'b1;
          next_op_rww  = cmd == CMD_RWW_WRITE;
          next_op_addr = page_base(nvm_addr);
        end
        CMD_ERASE_ROW, CMD_RWW_ERASE: begin
          if (row_locked) begin
            next_lock_err      = 1'b1;
            ev_set[IS_LOCKERR] = 1'b1;
          end else begin
            next_state   = S_ERASE;
            next_cnt     = CNT_W'(ERASE_CYC - 1);
            next_erase   = 1'b1;
            next_op_rww  = cmd == CMD_RWW_ERASE;
            next_op_addr = row_base(nvm_addr);
          end
        end
        CMD_BUF_CLEAR: begin
          buf_clear   = 1'b1;
          next_loaded = 1'b0;
        end
        default: ;
      endcase
    end
    if (mem_take) begin
      next_nvm_addr = mem_addr;
      next_loaded   = 1'b1;
    end
    if (auto_go) begin
      next_state   = S_PROG;
      next_cnt     = CNT_W'(PROG_CYC - 1);
      next_prog    = 1'b1;
      next_op_rww  = mem_rww;
      next_op_addr = page_base(mem_addr);
    end
    if (state != S_IDLE) begin
      if (cnt == '0) begin
        next_state      = S_IDLE;
        ev_set[IS_DONE] = 1'b1;
        if (state == S_PROG) begin
          buf_clear   = 1'b1;
          next_loaded = 1'b0;
        end
      end else begin
        next_cnt = cnt - CNT_W'(1);
      end
    end
    if (reg_wr) begin
      unique case (reg_addr)
        REG_CTRLB:   next_manual = reg_wdata[CB_MANUAL];
        REG_INTMASK: next_intmask = reg_wdata[IS_W-1:0];
        REG_LOCK:    next_lock_bits = reg_wdata[LOCK_REGIONS-1:0];
        REG_ADDR: begin
          if (!mem_take) begin
            next_nvm_addr = reg_wdata[ADDR_W-1:0];
          end
        end
        REG_STATUS: begin
          // write one clears; a new lock error in this cycle wins
          if (reg_wdata[ST_LOCKERR] && !ev_set[IS_LOCKERR]) begin
            next_lock_err = 1'b0;
          end
        end
        default: ;
      endcase
    end
  end

  // interrupt status: read clears, a set in the same cycle wins
  always_comb begin
    next_intstat = intstat;
    if (reg_rd && reg_addr == REG_INTSTAT) begin
      next_intstat = '0;
    end
    next_intstat = next_intstat | ev_set;
  end
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_CTRLB:   next_rdata[CB_MANUAL] = manual;
        REG_STATUS: begin
          next_rdata[ST_LOADED]  = loaded;
          next_rdata[ST_LOCKERR] = lock_err;
          next_rdata[ST_READY]   = state == S_IDLE;
        end
        REG_INTSTAT: next_rdata[IS_W-1:0] = intstat;
        REG_INTMASK: next_rdata[IS_W-1:0] = intmask;
        REG_ADDR:    next_rdata[ADDR_W-1:0] = nvm_addr;
        REG_LOCK:    next_rdata[LOCK_REGIONS-1:0] = lock_bits;
        default:     next_rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state       <= S_IDLE;
      cnt         <= '0;
      manual      <= MANUAL_RST;
      nvm_addr    <= '0;
      loaded      <= 1'b0;
      lock_err    <= 1'b0;
      intstat     <= '0;
      intmask     <= INTMASK_RST;
      lock_bits   <= '0;
      reg_rdata   <= '0;
      mem_stall   <= 1'b0;
      nvm_prog    <= 1'b0;
      nvm_erase   <= 1'b0;
      nvm_op_rww  <= 1'b0;
      nvm_op_addr <= '0;
      irq         <= 1'b0;
    end else begin
      state       <= next_state;
      cnt         <= next_cnt;
      manual      <= next_manual;
      nvm_addr    <= next_nvm_addr;
      loaded      <= next_loaded;
      lock_err    <= next_lock_err;
      intstat     <= next_intstat;
      intmask     <= next_intmask;
      lock_bits   <= next_lock_bits;
      reg_rdata   <= next_rdata;
      mem_stall   <= next_state != S_IDLE;
      nvm_prog    <= next_prog;
      nvm_erase   <= next_erase;
      nvm_op_rww  <= next_op_rww;
      nvm_op_addr <= next_op_addr;
      irq         <= |(next_intstat & next_intmask);
    end
  end

  page_buffer #(
    .WORDS (PAGE_WORDS),
    .W     (32)
  ) u_buf (
    .mclk    (mclk),
    .rstn    (rstn),
    .wr_en   (mem_take),
    .wr_idx  (mem_addr[PW_B-1:0]),
    .wr_data (mem_wdata),
    .clear   (buf_clear),
    .rd_idx  (pb_rd_idx),
    .rd_data (pb_rd_data)
  );

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  logic [CNT_W-1:0] stall_len;
  always_ff @(posedge mclk) begin
    if (!rstn || !mem_stall) begin
      stall_len <= '0;
    end else begin
      stall_len <= stall_len + CNT_W'(1);
    end
  end
  a_stall_busy: assert property (mem_stall == (state != S_IDLE))
    else $error("stall does not follow busy state");
  a_auto_start: assert property (auto_go |=> nvm_prog && mem_stall)
    else $error("auto program did not start");
  a_manual_hold: assert property (
    mem_take && manual && !cmd_go |=> !nvm_prog)
    else $error("program started in manual mode");
  a_addr_capture: assert property (
    mem_take |=> nvm_addr == $past(mem_addr) && loaded)
    else $error("address not captured on load");
  a_prog_page: assert property (
    nvm_prog |-> nvm_op_addr == page_base(nvm_addr))
    else $error("program address is not captured page");
  a_erase_row: assert property (
    nvm_erase |-> nvm_op_addr[RW_B-1:0] == '0)
    else $error("erase address not row aligned");
  a_lock_skip: assert property (
    cmd_go && (cmd == CMD_ERASE_ROW || cmd == CMD_RWW_ERASE)
    && row_locked |=> !mem_stall && !nvm_erase && lock_err)
    else $error("locked erase not refused");
  a_prog_len: assert property (
    $fell(mem_stall) && $past(state) == S_PROG
    |-> $past(stall_len) == CNT_W'(PROG_CYC - 1))
    else $error("program busy length wrong");
  a_prog_unload: assert property (
    state == S_PROG && cnt == '0 |=> !loaded && !mem_stall)
    else $error("buffer not reset after program");
  a_buf_clear: assert property (
    cmd_go && cmd == CMD_BUF_CLEAR |=> !loaded)
    else $error("buffer clear left loaded set");
  a_irq_level: assert property (irq == |(intstat & intmask))
    else $error("interrupt does not match status");

  c_auto_prog: cover property (auto_go ##1 nvm_prog);
  c_manual_prog: cover property (
    cmd_go && cmd == CMD_WRITE_PAGE ##1 nvm_prog);
  c_erase: cover property (nvm_erase && nvm_op_rww);
  c_lock_err: cover property ($rose(lock_err));
endmodule
`default_nettype wire

/* logic/nvm_seq_pkg.sv */
`default_nettype none
package nvm_seq_pkg;
  // clock and timing
  localparam int MCLK_MHZ    = 250;
  localparam int T_PROG_NS   = 2000;
  localparam int T_ERASE_NS  = 6000;
  localparam int PROG_CYC    = (T_PROG_NS * MCLK_MHZ + 999) / 1000;
  localparam int ERASE_CYC   = (T_ERASE_NS * MCLK_MHZ + 999) / 1000;
  localparam int CNT_W       = 16;

  // register offsets
  localparam logic [7:0] REG_CTRLA   = 8'h00;
  localparam logic [7:0] REG_CTRLB   = 8'h04;
  localparam logic [7:0] REG_STATUS  = 8'h08;
  localparam logic [7:0] REG_INTSTAT = 8'h0c;
  localparam logic [7:0] REG_INTMASK = 8'h10;
  localparam logic [7:0] REG_ADDR    = 8'h14;
  localparam logic [7:0] REG_LOCK    = 8'h18;

  // field positions
  localparam int CMD_LSB     = 0;
  localparam int CMD_W       = 7;
  localparam int KEY_LSB     = 8;
  localparam int KEY_W       = 8;
  localparam int CB_MANUAL   = 0;
  localparam int ST_LOADED   = 0;
  localparam int ST_LOCKERR  = 1;
  localparam int ST_READY    = 2;
  localparam int IS_DONE     = 0;
  localparam int IS_LOCKERR  = 1;
  localparam int IS_W        = 2;

  // commands and execute key
  localparam logic [CMD_W-1:0] CMD_ERASE_ROW  = 7'h02;
  localparam logic [CMD_W-1:0] CMD_WRITE_PAGE = 7'h04;
  localparam logic [CMD_W-1:0] CMD_RWW_ERASE  = 7'h1a;
  localparam logic [CMD_W-1:0] CMD_RWW_WRITE  = 7'h1c;
  localparam logic [CMD_W-1:0] CMD_BUF_CLEAR  = 7'h44;
  localparam logic [KEY_W-1:0] EXEC_KEY       = 8'ha5;

  // reset values
  localparam logic             MANUAL_RST  = 1'b0;
  localparam logic [IS_W-1:0]  INTMASK_RST = 2'h0;

  typedef enum logic [1:0] {S_IDLE, S_PROG, S_ERASE} seq_state_t;
endpackage
`default_nettype wire

/* logic/page_buffer.sv */
`default_nettype none
module page_buffer #(
  parameter int WORDS = 16,
  parameter int W     = 32
) (
  // clock and reset
  input  wire logic                     mclk,
  input  wire logic                     rstn,
  // load side
  input  wire logic                     wr_en,
  input  wire logic [$clog2(WORDS)-1:0] wr_idx,
  input  wire logic [W-1:0]             wr_data,
  input  wire logic                     clear,
  // fetch side
  input  wire logic [$clog2(WORDS)-1:0] rd_idx,
  output var  logic [W-1:0]             rd_data
);
  logic [W-1:0] mem [WORDS];

  // erased state of the buffer is all ones; a load in the clear cycle
  // lands on top of the cleared contents
  always_ff @(posedge mclk) begin
    if (!rstn || clear) begin
      for (int i = 0; i < WORDS; i++) begin
        mem[i] <= '1;
      end
    end
    if (rstn && wr_en) begin
      mem[wr_idx] <= wr_data;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      rd_data <= '1;
    end else begin
      rd_data <= mem[rd_idx];
    end
  end
endmodule
`default_nettype wire

/* verif/nvm_array_model.sv */
`default_nettype none
// array macro stand-in: fetches the page buffer word by word on a program
module nvm_array_model (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // operation start
  input  wire logic        nvm_prog,
  input  wire logic        nvm_op_rww,
  input  wire logic [15:0] nvm_op_addr,
  // buffer fetch
  output var  logic [3:0]  pb_rd_idx,
  input  wire logic [31:0] pb_rd_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] pg [16];
  logic [15:0] pg_addr;
  logic        pg_rww;
  initial pb_rd_idx = 4'h0;
  always @(posedge mclk) begin
    #1;
    if (rstn === 1'b1 && nvm_prog === 1'b1) begin
      pg_addr = nvm_op_addr;
      pg_rww  = nvm_op_rww;
      // buffer data arrive one cycle after the index, so read past the edge
      for (int i = 0; i < 16; i++) begin
        pb_rd_idx <= 4'(i);
        @(posedge mclk);
        #1;
        pg[i] = pb_rd_data;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/nvm_page_write_erase_tb.sv */
`default_nettype none
module nvm_page_write_erase_tb;
  import nvm_seq_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk;
  logic        rstn;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        mem_wr;
  logic        mem_rww;
  logic [15:0] mem_addr;
  logic [31:0] mem_wdata;
  logic        mem_stall;
  logic        nvm_prog;
  logic        nvm_erase;
  logic        nvm_op_rww;
  logic [15:0] nvm_op_addr;
  logic [3:0]  pb_rd_idx;
  logic [31:0] pb_rd_data;
  logic        irq;
  int          n_errors;
  int          checked;
  int          stall_cyc;
  logic [31:0] d;

  nvm_page_write_erase uut (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .mem_wr(mem_wr), .mem_rww(mem_rww), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_stall(mem_stall), .nvm_prog(nvm_prog),
    .nvm_erase(nvm_erase), .nvm_op_rww(nvm_op_rww),
    .nvm_op_addr(nvm_op_addr), .pb_rd_idx(pb_rd_idx),
    .pb_rd_data(pb_rd_data), .irq(irq));

  nvm_array_model model (
    .mclk(mclk), .rstn(rstn), .nvm_prog(nvm_prog), .nvm_op_rww(nvm_op_rww),
    .nvm_op_addr(nvm_op_addr), .pb_rd_idx(pb_rd_idx),
    .pb_rd_data(pb_rd_data));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  // sampled mid-cycle so the registered stall has settled
  always @(negedge mclk) begin
    if (mem_stall === 1'b1) stall_cyc++;
  end

  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, checked);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [31:0] cmdw(input logic [CMD_W-1:0] c,
                                       input logic [KEY_W-1:0] k);
    cmdw = 32'h0;
    cmdw[CMD_LSB +: CMD_W] = c;
    cmdw[KEY_LSB +: KEY_W] = k;
  endfunction

  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rreg(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic wmem(input logic [15:0] a, input logic [31:0] v,
                      input logic rww);
    @(posedge mclk);
    mem_wr    <= 1'b1;
    mem_addr  <= a;
    mem_wdata <= v;
    mem_rww   <= rww;
    @(posedge mclk);
    mem_wr    <= 1'b0;
  endtask

  task automatic op_start(input logic er, input logic rww,
                          input logic [15:0] base);
    #1;
    chk(er ? nvm_erase : nvm_prog, 32'h1);
    chk(nvm_op_rww, rww);
    chk(nvm_op_addr, base);
    stall_cyc = 0;
  endtask

  task automatic op_end(input int cyc);
    int n;
    n = 0;
    while (mem_stall !== 1'b0 && n < 4000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    if (n >= 4000) begin
      n_errors++;
      $display("Error at %0t: operation never finished", $time);
      summarize();
    end else begin
      chk(stall_cyc, cyc);
    end
  endtask

  task automatic t_reset();
    rreg(REG_STATUS, d);
    chk(d, 32'h4);
    rreg(8'hfc, d);
    chk(d, 32'h0);
    rreg(REG_INTMASK, d);
    chk(d, 32'h0);
    chk(pb_rd_data, 32'hffffffff);
    chk(irq, 1'b0);
  endtask

  task automatic t_erase();
    logic [6:0]  c [2];
    logic [15:0] a [2];
    logic [15:0] b [2];
    c = '{CMD_ERASE_ROW, CMD_RWW_ERASE};
    a = '{16'h0133, 16'h0277};
    b = '{16'h0100, 16'h0240};
    wreg(REG_LOCK, 32'h0008);
    wreg(REG_ADDR, 32'h3045);
    wreg(REG_CTRLA, cmdw(CMD_ERASE_ROW, EXEC_KEY));
    #1;
    chk(nvm_erase, 1'b0);
    chk(mem_stall, 1'b0);
    rreg(REG_STATUS, d);
    chk(d, 32'h6);
    rreg(REG_INTSTAT, d);
    chk(d, 32'h2);
    wreg(REG_STATUS, 32'h2);
    rreg(REG_STATUS, d);
    chk(d, 32'h4);
    for (int i = 0; i < 2; i++) begin
      wreg(REG_ADDR, {16'h0, a[i]});
      wreg(REG_CTRLA, cmdw(c[i], EXEC_KEY));
      op_start(1'b1, 1'(i), b[i]);
      op_end(ERASE_CYC);
    end
    rreg(REG_INTSTAT, d);
    chk(d, 32'h1);
  endtask

  task automatic t_manual();
    wreg(REG_CTRLB, 32'h1);
    for (int i = 0; i < 3; i++) wmem(16'h0120 + 16'(i), 32'h1000 + i, 1'b0);
    rreg(REG_STATUS, d);
    chk(d, 32'h5);
    rreg(REG_ADDR, d);
    chk(d, 32'h0122);
    wreg(REG_CTRLA, cmdw(CMD_WRITE_PAGE, 8'h5a));
    #1;
    chk(mem_stall, 1'b0);
    wreg(REG_CTRLA, cmdw(CMD_WRITE_PAGE, EXEC_KEY));
    op_start(1'b0, 1'b0, 16'h0120);
    wmem(16'h0125, 32'hdead0000, 1'b0);
    rreg(REG_STATUS, d);
    chk(d, 32'h1);
    op_end(PROG_CYC);
    rreg(REG_STATUS, d);
    chk(d, 32'h4);
    for (int i = 0; i < 16; i++)
      chk(model.pg[i], i < 3 ? 32'h1000 + i : 32'hffffffff);
    chk(pb_rd_data, 32'hffffffff);
    chk(irq, 1'b0);
    rreg(REG_INTSTAT, d);
    chk(d, 32'h1);
  endtask

  task automatic t_auto();
    wreg(REG_INTMASK, 32'h1);
    wreg(REG_CTRLB, 32'h0);
    for (int i = 0; i < 16; i++) wmem(16'h0240 + 16'(i), 32'h2000 + i, 1'b1);
    op_start(1'b0, 1'b1, 16'h0240);
    op_end(PROG_CYC);
    chk(irq, 1'b1);
    rreg(REG_INTSTAT, d);
    chk(d, 32'h1);
    @(posedge mclk);
    #1;
    chk(irq, 1'b0);
    for (int i = 0; i < 16; i++) chk(model.pg[i], 32'h2000 + i);
    chk(model.pg_rww, 1'b1);
  endtask

  task automatic t_clear();
    wreg(REG_CTRLB, 32'h1);
    wmem(16'h030f, 32'h5a5a5a5a, 1'b0);
    #1;
    chk(mem_stall, 1'b0);
    rreg(REG_STATUS, d);
    chk(d, 32'h5);
    chk(pb_rd_data, 32'h5a5a5a5a);
    wreg(REG_CTRLA, cmdw(CMD_BUF_CLEAR, EXEC_KEY));
    rreg(REG_STATUS, d);
    chk(d, 32'h4);
    chk(pb_rd_data, 32'hffffffff);
    // manual commit of a partial page into the rww array
    wmem(16'h0251, 32'h3c3c3c3c, 1'b1);
    wreg(REG_CTRLA, cmdw(CMD_RWW_WRITE, EXEC_KEY));
    op_start(1'b0, 1'b1, 16'h0250);
    op_end(PROG_CYC);
    chk(model.pg[1], 32'h3c3c3c3c);
    chk(model.pg[0], 32'hffffffff);
    chk(model.pg_rww, 1'b1);
  endtask

  initial begin
    n_errors  = 0;
    checked   = 0;
    stall_cyc = 0;
    rstn      = 1'b0;
    reg_addr  = 8'h0;
    reg_wdata = 32'h0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    mem_wr    = 1'b0;
    mem_rww   = 1'b0;
    mem_addr  = 16'h0;
    mem_wdata = 32'h0;
    repeat (5) @(posedge mclk);
    rstn <= 1'b1;
    t_reset();
    t_erase();
    t_manual();
    t_auto();
    t_clear();
    summarize();
  end
endmodule
`default_nettype wire
